// *** rtl/uart_mc_pkg.sv ***
// package: register offsets, bit positions, reset values and frame timing for the modem block
package uart_mc_pkg;
    // register offsets on the processor port (byte addresses)
    localparam logic [9:0] OFF_RX_BUF = 10'h3f8;
    localparam logic [9:0] OFF_INT_EN = 10'h3f9;
    localparam logic [9:0] OFF_LINE_CTRL = 10'h3fb;
    localparam logic [9:0] OFF_MODEM_CTRL = 10'h3fc;
    localparam logic [9:0] OFF_MODEM_STAT = 10'h3fe;
    // modem control bit positions
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_AUX1 = 2;
    localparam int MC_AUX2 = 3;
    localparam int MC_LOOP = 4;
    localparam logic [7:0] MC_WRITE_MASK = 8'h1f;
    // interrupt enable bit position and writable mask
    localparam int IE_MODEM = 3;
    localparam logic [7:0] IE_WRITE_MASK = 8'h0f;
    // divisor latch access bit position in the line control register
    localparam int LC_DIVISOR_LATCH_ACCESS_BIT = 7;
    // reset values
    localparam logic [7:0] MC_RESET = 8'h00;
    localparam logic [7:0] IE_RESET = 8'h00;
    localparam logic [7:0] LC_RESET = 8'h00;
    // serial frame: one start, eight data, one stop
    localparam int DATA_BITS = 8;
    localparam int FRAME_BITS = 10;
    // default bit time in clock cycles
    localparam int BIT_CYCLES_DEF = 16;
endpackage

// *** rtl/ser_link_if.sv ***
// interface: serial character path between register logic and the shifter
`timescale 1ns/100ps
interface ser_link_if;
    logic [7:0] tx_data; // character to send
    logic tx_load; // one-cycle load strobe
    logic tx_busy; // shifter occupied
    logic [7:0] rx_data; // last assembled character
    logic rx_done; // one-cycle character done strobe
    logic tx_bit; // shift register output
    logic rx_bit; // shift register input (already synchronised / looped)
    modport ctl
    (
        output tx_data, tx_load, rx_bit,
        input tx_busy, rx_data, rx_done, tx_bit
    );
    modport shf
    (
        input tx_data, tx_load, rx_bit,
        output tx_busy, rx_data, rx_done, tx_bit
    );
endinterface

// *** rtl/uart_shifter.sv ***
// module: lsb-first transmit and receive shift registers
`timescale 1ns/100ps
module uart_shifter
    import uart_mc_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF // clocks per serial bit
)
(
    input wire logic clk_in, // system clock
    input wire logic rstn_in, // async reset, active low
    ser_link_if.shf lnk // character path
);
    localparam int CW = $clog2(BIT_CYCLES + 1);

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    logic [9:0] tx_sh_r; // frame being sent, lsb goes first
    logic [3:0] tx_cnt_r; // bits left in frame
    logic [CW-1:0] tx_tick_r; // cycles left in bit

    // load a frame, then shift lsb first once per bit time
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            tx_sh_r <= 10'h3ff;
            tx_cnt_r <= 4'h0;
            tx_tick_r <= '0;
        end
        else if (lnk.tx_load && tx_cnt_r == 4'h0)
        begin
            // stop, data, start: bit 0 of the data follows the start bit
            tx_sh_r <= {1'b1, lnk.tx_data, 1'b0};
            tx_cnt_r <= 4'(FRAME_BITS);
            tx_tick_r <= CW'(BIT_CYCLES - 1);
        end
        else if (tx_cnt_r != 4'h0)
        begin
            if (tx_tick_r == '0)
            begin
                tx_sh_r <= {1'b1, tx_sh_r[9:1]};
                tx_cnt_r <= tx_cnt_r - 4'h1;
                tx_tick_r <= CW'(BIT_CYCLES - 1);
            end
            else
            begin
                tx_tick_r <= tx_tick_r - 1'b1;
            end
        end
    end

    assign lnk.tx_bit = tx_sh_r[0];
    assign lnk.tx_busy = (tx_cnt_r != 4'h0);

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    logic [7:0] rx_sh_r; // assembling character
    logic [3:0] rx_cnt_r; // bits still to sample, 0 = idle
    logic [CW-1:0] rx_tick_r; // cycles to next sample
    logic [7:0] rx_data_r; // finished character
    logic rx_done_r; // completion strobe

    // start on a low level while idle, sample mid-bit, first bit lands in bit 0
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rx_sh_r <= 8'h00;
            rx_cnt_r <= 4'h0;
            rx_tick_r <= '0;
            rx_data_r <= 8'h00;
            rx_done_r <= 1'b0;
        end
        else
        begin
            rx_done_r <= 1'b0;
            if (rx_cnt_r == 4'h0)
            begin
                if (!lnk.rx_bit)
                begin
                    // wait half a bit to land mid start bit
                    rx_cnt_r <= 4'(FRAME_BITS);
                    rx_tick_r <= CW'(BIT_CYCLES / 2);
                end
            end
            else if (rx_tick_r != '0)
            begin
                rx_tick_r <= rx_tick_r - 1'b1;
            end
            else
            begin
                rx_tick_r <= CW'(BIT_CYCLES - 1);
                rx_cnt_r <= rx_cnt_r - 4'h1;
                if (rx_cnt_r == 4'(FRAME_BITS) && lnk.rx_bit)
                begin
                    rx_cnt_r <= 4'h0; // glitch, not a real start bit
                end
                else if (rx_cnt_r == 4'h1)
                begin
                    rx_data_r <= rx_sh_r; // stop bit reached
                    rx_done_r <= 1'b1;
                end
                else if (rx_cnt_r != 4'(FRAME_BITS))
                begin
                    rx_sh_r <= {lnk.rx_bit, rx_sh_r[7:1]};
                end
            end
        end
    end

    assign lnk.rx_data = rx_data_r;
    assign lnk.rx_done = rx_done_r;
endmodule

// *** rtl/uart_modem_control_loopback.sv ***
// module: register port, modem handshake lines, loopback and modem status interrupt
`timescale 1ns/100ps

module uart_modem_control_loopback
    import uart_mc_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF // clocks per serial bit
)
(
    input wire logic clk_in, // system clock, 250 MHz
    input wire logic rstn_in, // async reset, active low
    input wire logic [9:0] addr_in, // processor address
    input wire logic [7:0] wdata_in, // processor write data
    input wire logic wr_in, // one-cycle write strobe
    input wire logic rd_in, // one-cycle read strobe
    output logic [7:0] rdata_out, // read data, registered
    output logic interrupt_request_out, // modem status interrupt, high
    output logic serial_tx_pin, // serial transmit data
    input wire logic serial_rx_pin, // serial receive data
    input wire logic cts_n_in, // clear to send, active low
    input wire logic dsr_n_in, // data set ready, active low
    input wire logic ri_n_in, // ring indicator, active low
    input wire logic carrier_detect_in, // carrier detect, active low level at pin
    output logic dtr_n_out, // data terminal ready, active low
    output logic rts_n_out, // request to send, active low
    output logic aux_out_1, // auxiliary output 1, active low
    output logic aux_out_2 // auxiliary output 2, active low
);
    import uart_mc_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // one decode used by both the write and the read paths
    function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
        hit = (a == off);
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [4:0] pin_s1_r; // first stage, read only by second stage
    logic [4:0] pin_s2_r; // stable copies: rx, cts, dsr, ri, carrier

    // two flops before any logic looks at a pin
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pin_s1_r <= 5'h1f;
            pin_s2_r <= 5'h1f;
        end
        else
        begin
            pin_s1_r <= {serial_rx_pin, cts_n_in, dsr_n_in, ri_n_in, carrier_detect_in};
            pin_s2_r <= pin_s1_r;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic [7:0] modem_line_control_r; // handshake and loopback control
    logic [7:0] interrupt_enable_register_r; // interrupt enables
    logic [7:0] line_ctrl_r; // all eight written bits kept; only the divisor latch access bit is used
    logic [7:0] transmit_holding_r; // character waiting to go
    logic thr_full_r; // holding register occupied
    logic [7:0] receive_buffer_r; // last received character
    logic divisor_latch_access_bit;
    logic loop_on;

    assign divisor_latch_access_bit = line_ctrl_r[LC_DIVISOR_LATCH_ACCESS_BIT];
    assign loop_on = modem_line_control_r[MC_LOOP];

    // software writes; unused high bits of control stay zero
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            modem_line_control_r <= MC_RESET;
            interrupt_enable_register_r <= IE_RESET;
            line_ctrl_r <= LC_RESET;
        end
        else if (wr_in)
        begin
            if (hit(addr_in, OFF_MODEM_CTRL))
            begin
                modem_line_control_r <= wdata_in & MC_WRITE_MASK;
            end
            // enable register shares the divisor high byte when the latch bit is set
            if (hit(addr_in, OFF_INT_EN) && !divisor_latch_access_bit)
            begin
                interrupt_enable_register_r <= wdata_in & IE_WRITE_MASK;
            end
            if (hit(addr_in, OFF_LINE_CTRL))
            begin
                line_ctrl_r <= wdata_in;
            end
        end
    end

    // ----------------------------------------
    // serial path
    // ----------------------------------------
    ser_link_if lnk();
    logic tx_load_r; // launch strobe to shifter

    // holding register fed by writes at the base offset; drained when shifter is free
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            transmit_holding_r <= 8'h00;
            thr_full_r <= 1'b0;
            tx_load_r <= 1'b0;
        end
        else
        begin
            tx_load_r <= 1'b0;
            if (wr_in && hit(addr_in, OFF_RX_BUF) && !divisor_latch_access_bit)
            begin
                transmit_holding_r <= wdata_in;
                thr_full_r <= 1'b1;
            end
            else if (thr_full_r && !lnk.tx_busy && !tx_load_r)
            begin
                tx_load_r <= 1'b1;
                thr_full_r <= 1'b0;
            end
        end
    end

    assign lnk.tx_data = transmit_holding_r;
    assign lnk.tx_load = tx_load_r;
    // loopback ignores the pin and listens to our own shifter
    assign lnk.rx_bit = loop_on ? lnk.tx_bit : pin_s2_r[4];

    uart_shifter #(.BIT_CYCLES(BIT_CYCLES)) u_shf
    (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .lnk(lnk)
    );

    // capture each finished character
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            receive_buffer_r <= 8'h00;
        end
        else if (lnk.rx_done)
        begin
            receive_buffer_r <= lnk.rx_data;
        end
    end

    // ----------------------------------------
    // handshake outputs
    // ----------------------------------------
    // inverted sense; loopback leaves these pins following and parks tx at mark
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            dtr_n_out <= 1'b1;
            rts_n_out <= 1'b1;
            aux_out_1 <= 1'b1;
            aux_out_2 <= 1'b1;
            serial_tx_pin <= 1'b1;
        end
        else
        begin
            dtr_n_out <= ~modem_line_control_r[MC_DTR];
            rts_n_out <= ~modem_line_control_r[MC_RTS];
            aux_out_1 <= ~modem_line_control_r[MC_AUX1];
            aux_out_2 <= ~modem_line_control_r[MC_AUX2];
            serial_tx_pin <= loop_on ? 1'b1 : lnk.tx_bit;
        end
    end

    // ----------------------------------------
    // modem status
    // ----------------------------------------
    // current state, true sense: cts, dsr, ri, carrier
    logic [3:0] cur_state; // status bits 4..7 order
    logic [3:0] prev_state_r; // state one cycle earlier
    logic [3:0] delta_r; // change flags, status bits 0..3
    logic ms_read;
    logic ms_write;
    logic [3:0] delta_set;

    // loopback: cts<-rts, dsr<-dtr, ri<-aux1, carrier<-aux2
    always_comb
    begin
        if (loop_on)
        begin
            cur_state = {modem_line_control_r[MC_AUX2], modem_line_control_r[MC_AUX1],
                         modem_line_control_r[MC_DTR], modem_line_control_r[MC_RTS]};
        end
        else
        begin
            // pins are active low, so complement gives the on state
            cur_state = {~pin_s2_r[0], ~pin_s2_r[1], ~pin_s2_r[2], ~pin_s2_r[3]};
        end
    end

    assign ms_read = rd_in && hit(addr_in, OFF_MODEM_STAT);
    assign ms_write = wr_in && hit(addr_in, OFF_MODEM_STAT);

    // change detection; ring flags only the on-to-off edge
    always_comb
    begin
        delta_set = 4'h0;
        delta_set[0] = cur_state[0] ^ prev_state_r[0];
        delta_set[1] = cur_state[1] ^ prev_state_r[1];
        delta_set[2] = prev_state_r[2] & ~cur_state[2];
        delta_set[3] = cur_state[3] ^ prev_state_r[3];
        if (ms_write)
        begin
            delta_set = delta_set | wdata_in[3:0];
        end
    end

    // a change in the same cycle as a read survives: set wins over clear
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            prev_state_r <= 4'h0;
            delta_r <= 4'h0;
        end
        else
        begin
            prev_state_r <= cur_state;
            delta_r <= (ms_read ? 4'h0 : delta_r) | delta_set;
        end
    end

    // modem interrupt only, gated by its enable even in loopback
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            interrupt_request_out <= 1'b0;
        end
        else
        begin
            interrupt_request_out <= (|delta_r) &
                interrupt_enable_register_r[IE_MODEM];
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    // registered read data, zero for unmapped offsets
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rdata_out <= 8'h00;
        end
        else if (rd_in)
        begin
            if (hit(addr_in, OFF_RX_BUF) && !divisor_latch_access_bit)
            begin
                rdata_out <= receive_buffer_r;
            end
            else if (hit(addr_in, OFF_INT_EN) && !divisor_latch_access_bit)
            begin
                rdata_out <= interrupt_enable_register_r;
            end
            else if (hit(addr_in, OFF_LINE_CTRL))
            begin
                rdata_out <= line_ctrl_r;
            end
            else if (hit(addr_in, OFF_MODEM_CTRL))
            begin
                rdata_out <= modem_line_control_r;
            end
            else if (hit(addr_in, OFF_MODEM_STAT))
            begin
                rdata_out <= {cur_state, delta_r};
            end
            else
            begin
                rdata_out <= 8'h00;
            end
        end
    end
endmodule

// *** sim/modem_partner.sv ***
// modem model: drives handshake and receive lines, samples the transmit line
`timescale 1ns/100ps
module modem_partner
#(
    parameter int BIT_CYCLES = 4 // clocks per serial bit
)
(
    input wire logic clk_in, // bench clock
    input wire logic serial_tx_pin, // line from the device
    output logic serial_rx_pin, // line into the device
    output logic [3:0] lines_n_out // carrier, ring, dsr, cts; active low
);
    // idle line rests at mark, handshake lines inactive
    initial
    begin
        serial_rx_pin = 1'b1;
        lines_n_out = 4'hf;
    end

    // set handshake levels and the receive line level
    task automatic drive(input logic [3:0] v, input logic rx);
        lines_n_out = v;
        serial_rx_pin = rx;
    endtask

    // one frame: start, eight data bits lowest first, stop
    task automatic send_char(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(negedge clk_in);
            serial_rx_pin = f[i];
            repeat (BIT_CYCLES - 1) @(negedge clk_in);
        end
    endtask

    // bounded hunt for a start bit, then mid-bit sampling
    task automatic get_char(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        b = 8'h00;
        while (serial_tx_pin !== 1'b0 && n < 400)
        begin
            @(negedge clk_in);
            n++;
        end
        if (n < 400)
        begin
            repeat (BIT_CYCLES / 2) @(negedge clk_in);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CYCLES) @(negedge clk_in);
                b[i] = serial_tx_pin;
            end
            repeat (BIT_CYCLES) @(negedge clk_in);
            ok = (serial_tx_pin === 1'b1);
        end
    endtask
endmodule

// *** sim/uart_mc_assertions.sv ***
// checker: port-level properties of the modem control and loopback block
`timescale 1ns/100ps
module uart_mc_assertions
    import uart_mc_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF // clocks per serial bit
)
(
    input wire logic clk_in, // clock
    input wire logic rstn_in, // reset, active low
    input wire logic [9:0] addr_in, // address
    input wire logic [7:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    input wire logic [7:0] rdata_out, // read data
    input wire logic interrupt_request_out, // modem interrupt
    input wire logic serial_tx_pin, // serial out
    input wire logic serial_rx_pin, // serial in
    input wire logic cts_n_in, // cts
    input wire logic dsr_n_in, // dsr
    input wire logic ri_n_in, // ring
    input wire logic carrier_detect_in, // carrier
    input wire logic dtr_n_out, // dtr
    input wire logic rts_n_out, // rts
    input wire logic aux_out_1, // aux 1
    input wire logic aux_out_2 // aux 2
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    logic [4:0] mc_r; // shadow of the control register
    logic ie3_r; // shadow of the modem interrupt enable
    logic divisor_latch_access_bit_r; // shadow of the latch access bit
    logic [3:0] pins_r; // last seen modem lines
    logic [2:0] quiet_r; // cycles since lines or control moved
    logic wr_mc; // control write
    logic rd_ms; // status read
    assign wr_mc = wr_in && (addr_in == OFF_MODEM_CTRL);
    assign rd_ms = rd_in && (addr_in == OFF_MODEM_STAT);

    // register shadows follow the processor writes
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            mc_r <= 5'h00;
            ie3_r <= 1'b0;
            divisor_latch_access_bit_r <= 1'b0;
        end
        else
        begin
            if (wr_mc)
                mc_r <= wdata_in[4:0];
            if (wr_in && addr_in == OFF_INT_EN && !divisor_latch_access_bit_r)
                ie3_r <= wdata_in[IE_MODEM];
            if (wr_in && addr_in == OFF_LINE_CTRL)
                divisor_latch_access_bit_r <= wdata_in[LC_DIVISOR_LATCH_ACCESS_BIT];
        end
    end

    // quiet counter: status bits lag the lines through synchronisers
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            pins_r <= 4'hf;
            quiet_r <= 3'h0;
        end
        else
        begin
            pins_r <= {carrier_detect_in, ri_n_in, dsr_n_in, cts_n_in};
            if (wr_mc || pins_r != {carrier_detect_in, ri_n_in, dsr_n_in, cts_n_in})
                quiet_r <= 3'h0;
            else if (quiet_r != 3'h7)
                quiet_r <= quiet_r + 3'h1;
        end
    end

    a_dtr_rts_drive:
        assert property (wr_mc |-> ##2 {rts_n_out, dtr_n_out} == ~$past(wdata_in[1:0], 2))
        else $error("dtr or rts not inverse of control bits");
    a_aux_drive:
        assert property (wr_mc |-> ##2 {aux_out_2, aux_out_1} == ~$past(wdata_in[3:2], 2))
        else $error("aux outputs not inverse of control bits");
    a_loop_tx_mark:
        assert property (mc_r[MC_LOOP] && $past(mc_r[MC_LOOP]) |-> serial_tx_pin)
        else $error("transmit pin left mark in loopback");
    a_ctrl_readback:
        assert property (rd_in && addr_in == OFF_MODEM_CTRL |=> rdata_out == {3'b000, $past(mc_r)})
        else $error("control readback wrong");
    a_irq_gated:
        assert property (!ie3_r && !$past(ie3_r) |-> !interrupt_request_out)
        else $error("interrupt while disabled");
    a_flags_raise_irq:
        assert property (rd_ms && ie3_r |=> interrupt_request_out == (rdata_out[3:0] != 4'h0))
        else $error("interrupt does not match change flags");
    a_read_clears_irq:
        assert property (rd_ms && quiet_r == 3'h7 |-> ##2 !interrupt_request_out)
        else $error("interrupt stays after status read");
    a_status_lines:
        assert property (rd_ms && quiet_r == 3'h7 && !mc_r[MC_LOOP] |=>
            rdata_out[7:4] == ~$past({carrier_detect_in, ri_n_in, dsr_n_in, cts_n_in}))
        else $error("status line bits wrong");
    a_loop_status:
        assert property (rd_ms && quiet_r == 3'h7 && mc_r[MC_LOOP] |=>
            rdata_out[7:4] == $past({mc_r[MC_AUX2], mc_r[MC_AUX1], mc_r[MC_DTR], mc_r[MC_RTS]}))
        else $error("loopback status bits wrong");

    c_irq_up: cover property ($rose(interrupt_request_out));
    c_loop_read: cover property (rd_ms && mc_r[MC_LOOP]);
    c_tx_start: cover property ($fell(serial_tx_pin));
endmodule

bind uart_modem_control_loopback uart_mc_assertions #(.BIT_CYCLES(BIT_CYCLES)) u_chk (
    .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .interrupt_request_out(interrupt_request_out), .serial_tx_pin(serial_tx_pin),
    .serial_rx_pin(serial_rx_pin), .cts_n_in(cts_n_in), .dsr_n_in(dsr_n_in),
    .ri_n_in(ri_n_in), .carrier_detect_in(carrier_detect_in), .dtr_n_out(dtr_n_out),
    .rts_n_out(rts_n_out), .aux_out_1(aux_out_1), .aux_out_2(aux_out_2));

// *** sim/tb.sv ***
// bench: drives block and modem model, checks registers, lines and frames
`timescale 1ns/100ps
module tb;
    import uart_mc_pkg::*;
    localparam int BC = 4; // short bit time keeps frames quick
    // loopback steps: control value, expected status
    localparam logic [15:0] STEPS [5] = '{16'h1122, 16'h1560, 16'h1124, 16'h19a8, 16'h1bb1};
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [9:0] addr_in = 10'h000;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic interrupt_request_out, serial_tx_pin, serial_rx_pin;
    logic dtr_n_out, rts_n_out, aux_out_1, aux_out_2;
    logic [3:0] lines_n; // carrier, ring, dsr, cts from the modem
    int fail_count = 0;
    int tests_run = 0;

    always #2 clk_in = ~clk_in;

    uart_modem_control_loopback #(.BIT_CYCLES(BC)) u_dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .interrupt_request_out(interrupt_request_out), .serial_tx_pin(serial_tx_pin),
        .serial_rx_pin(serial_rx_pin), .cts_n_in(lines_n[0]), .dsr_n_in(lines_n[1]),
        .ri_n_in(lines_n[2]), .carrier_detect_in(lines_n[3]), .dtr_n_out(dtr_n_out),
        .rts_n_out(rts_n_out), .aux_out_1(aux_out_1), .aux_out_2(aux_out_2));
    modem_partner #(.BIT_CYCLES(BC)) u_modem (
        .clk_in(clk_in), .serial_tx_pin(serial_tx_pin),
        .serial_rx_pin(serial_rx_pin), .lines_n_out(lines_n));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle strobes, launched off the falling edge
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_in = a;
        wdata_in = d;
        wr_in = 1'b1;
        @(negedge clk_in);
        wr_in = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(negedge clk_in);
        addr_in = a;
        rd_in = 1'b1;
        @(negedge clk_in);
        rd_in = 1'b0;
        @(negedge clk_in);
        d = rdata_out;
    endtask
    task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        check(d, e);
    endtask
    task automatic irqchk(input logic e);
        check({7'h00, interrupt_request_out}, {7'h00, e});
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // status byte from old and new active-low lines; ring flags only on release
    function automatic logic [7:0] exp_stat(input logic [3:0] o, input logic [3:0] n);
        logic [3:0] f;
        f = o ^ n;
        f[2] = ~o[2] & n[2];
        return {~n, f};
    endfunction

    initial
    begin
        logic [7:0] d, b;
        logic [3:0] o, n;
        logic ok;
        b = 8'($urandom(32'h7135cd05));
        repeat (2) @(negedge clk_in);
        rstn_in = 1'b1;
        rdchk(OFF_MODEM_CTRL, MC_RESET);
        check({dtr_n_out, rts_n_out, aux_out_1, aux_out_2, 4'h0}, 8'hf0);
        // test-mode flags stay silent until enabled
        wr(OFF_MODEM_STAT, 8'h0f);
        repeat (3) @(negedge clk_in);
        irqchk(1'b0);
        wr(OFF_INT_EN, 8'h08);
        repeat (3) @(negedge clk_in);
        irqchk(1'b1);
        rdchk(OFF_MODEM_STAT, 8'h0f);
        irqchk(1'b0);
        // latch bit hides the low offsets; unmapped reads give zero
        wr(OFF_LINE_CTRL, 8'h80);
        wr(OFF_INT_EN, 8'h00);
        rdchk(OFF_RX_BUF, 8'h00);
        wr(OFF_LINE_CTRL, 8'h00);
        rdchk(OFF_INT_EN, 8'h08);
        rdchk(10'h3ff, 8'h00);
        // modem lines: walk each one both ways, then random
        o = 4'hf;
        for (int i = 0; i < 24; i++)
        begin
            n = (i < 8) ? o ^ (4'h1 << (i % 4)) : 4'($urandom());
            u_modem.drive(n, 1'b1);
            repeat (8) @(negedge clk_in);
            b = exp_stat(o, n);
            irqchk(b[3:0] != 4'h0);
            rdchk(OFF_MODEM_STAT, b);
            rdchk(OFF_MODEM_STAT, {b[7:4], 4'h0});
            o = n;
        end
        // control register: upper bits, pins, loopback status routing
        for (int i = 0; i < 16; i++)
        begin
            d = (i == 0) ? 8'hff : (i == 1) ? 8'he0 : 8'($urandom());
            wr(OFF_MODEM_CTRL, d);
            rdchk(OFF_MODEM_CTRL, {3'b000, d[4:0]});
            check({aux_out_2, aux_out_1, rts_n_out, dtr_n_out}, 8'h0f & ~d);
            repeat (8) @(negedge clk_in);
            rd(OFF_MODEM_STAT, b);
            check(b[7:4], d[4] ? {d[3], d[2], d[0], d[1]} : 4'hf ^ lines_n);
            rd(OFF_MODEM_STAT, b);
        end
        // loopback interrupts come from the control bits
        wr(OFF_MODEM_CTRL, 8'h10);
        repeat (8) @(negedge clk_in);
        rd(OFF_MODEM_STAT, b);
        foreach (STEPS[i])
        begin
            wr(OFF_MODEM_CTRL, STEPS[i][15:8]);
            repeat (8) @(negedge clk_in);
            irqchk(STEPS[i][3:0] != 4'h0);
            rdchk(OFF_MODEM_STAT, STEPS[i][7:0]);
        end
        // looped character arrives while the receive pin sits at space
        u_modem.drive(lines_n, 1'b0);
        b = 8'($urandom());
        wr(OFF_RX_BUF, b);
        repeat (60) @(negedge clk_in);
        check({7'h00, serial_tx_pin}, 8'h01);
        rdchk(OFF_RX_BUF, b);
        u_modem.drive(lines_n, 1'b1);
        wr(OFF_MODEM_CTRL, 8'h10);
        wr(OFF_MODEM_CTRL, 8'h00);
        repeat (8) @(negedge clk_in);
        rd(OFF_MODEM_STAT, b);
        // full duplex frames with boundary bytes first
        for (int i = 0; i < 6; i++)
        begin
            b = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($urandom());
            fork
                wr(OFF_RX_BUF, b);
                u_modem.get_char(d, ok);
                u_modem.send_char(~b);
            join
            check({7'h00, ok}, 8'h01);
            if (ok !== 1'b1)
                give_verdict();
            check(d, b);
            repeat (2 * BC) @(negedge clk_in);
            rdchk(OFF_RX_BUF, ~b);
        end
        give_verdict();
    end
endmodule
